// >>> common/ppe_regs.vh
// Constants for the paged EEPROM host controller
`ifndef PPE_REGS_VH
`define PPE_REGS_VH
`define PPE_ADDR_W 17
`define PPE_PAGE_LSB 7
`define PPE_PAGE_BYTES 128
`define PPE_CLK_MHZ 20
`define PPE_STROBE_NS 250
`define PPE_STROBE_CYC ((`PPE_STROBE_NS * `PPE_CLK_MHZ + 999) / 1000)
`define PPE_GAP_NS 150
`define PPE_GAP_CYC ((`PPE_GAP_NS * `PPE_CLK_MHZ + 999) / 1000)
`define PPE_RD_NS 300
`define PPE_RD_CYC ((`PPE_RD_NS * `PPE_CLK_MHZ + 999) / 1000)
`define PPE_BLC_US 150
`define PPE_BLC_CYC ((`PPE_BLC_US * `PPE_CLK_MHZ) - 12)
`define PPE_WC_MS 10
`define PPE_WC_CYC (`PPE_WC_MS * 1000 * `PPE_CLK_MHZ)
`define PPE_PWR_MS 5
`define PPE_PWR_CYC (`PPE_PWR_MS * 1000 * `PPE_CLK_MHZ)
`define PPE_UNL_A0 17'h05555
`define PPE_UNL_D0 8'haa
`define PPE_UNL_A1 17'h02aaa
`define PPE_UNL_D1 8'h55
`define PPE_UNL_A2 17'h05555
`define PPE_UNL_D2 8'ha0
`endif

// >>> logic/ppe_host.v
// Host controller driving a paged parallel EEPROM through its pins
// Contract
// - Host sends the three-write unlock sequence before every page load.
// - Host issues each next byte within the byte load window.
// - Host keeps the page address fixed for a whole page load.
// - Host polls only once a page load ends: after its last byte, at window expiry, or on a write to another page.
`timescale 1ns/1ps
`include "ppe_regs.vh"
module ppe_host #(
    parameter BLC_CYC = `PPE_BLC_CYC,
    parameter WC_CYC = `PPE_WC_CYC,
    parameter PWR_CYC = `PPE_PWR_CYC
) (
    input wire i_clk,
    input wire i_reset,
    input wire i_ce,
    input wire i_rd_req,
    input wire [16:0] i_rd_addr,
    input wire i_wr_req,
    input wire [16:0] i_wr_addr,
    input wire [7:0] i_wr_data,
    input wire i_wr_last,
    input wire [7:0] i_mem_data,
    output reg o_rd_valid,
    output reg [7:0] o_rd_data,
    output reg o_wr_ack,
    output reg o_busy,
    output reg o_timeout,
    output reg [16:0] o_mem_addr,
    output reg [7:0] o_mem_data,
    output reg o_mem_data_oe,
    output reg o_chip_enable_n,
    output reg o_output_enable_n,
    output reg o_write_enable_n
);
// ------------------------------------------------
// States
// ------------------------------------------------
localparam S_PWR = 8'h01;
localparam S_IDLE = 8'h02;
localparam S_WSTB = 8'h04;
localparam S_WGAP = 8'h08;
localparam S_LOAD = 8'h10;
localparam S_RSTB = 8'h20;
localparam S_RGAP = 8'h40;
localparam S_POLL = 8'h80;
reg [7:0] st_q;
reg [23:0] cnt_q;
reg [23:0] wc_q;
reg [1:0] unl_q;
reg unl_done_q;
reg [9:0] page_q;
reg [7:0] last_d_q;
reg [16:0] last_a_q;
reg poll_q;
reg [7:0] in_s1_q;
reg [7:0] in_s2_q;
reg [16:0] pend_a_q;
reg [7:0] pend_d_q;
reg pend_last_q;
function [24:0] unl_pair;
    input [1:0] idx;
    begin
        case (idx)
            2'd0: unl_pair = {`PPE_UNL_A0, `PPE_UNL_D0};
            2'd1: unl_pair = {`PPE_UNL_A1, `PPE_UNL_D1};
            default: unl_pair = {`PPE_UNL_A2, `PPE_UNL_D2};
        endcase
    end
endfunction
wire [24:0] unl_first = unl_pair(2'd0);
wire [24:0] unl_next = unl_pair(unl_q + 2'd1);
// ------------------------------------------------
// Sequencer
// ------------------------------------------------
always @(posedge i_clk)
begin
    if (i_reset)
    begin
        st_q <= S_PWR;
        cnt_q <= 24'h000000;
        wc_q <= 24'h000000;
        unl_q <= 2'd0;
        unl_done_q <= 1'b0;
        page_q <= 10'h000;
        last_d_q <= 8'h00;
        last_a_q <= 17'h00000;
        poll_q <= 1'b0;
        in_s1_q <= 8'h00;
        in_s2_q <= 8'h00;
        pend_a_q <= 17'h00000;
        pend_d_q <= 8'h00;
        pend_last_q <= 1'b0;
        o_rd_valid <= 1'b0;
        o_rd_data <= 8'h00;
        o_wr_ack <= 1'b0;
        o_busy <= 1'b1;
        o_timeout <= 1'b0;
        o_mem_addr <= 17'h00000;
        o_mem_data <= 8'h00;
        o_mem_data_oe <= 1'b0;
        o_chip_enable_n <= 1'b1;
        o_output_enable_n <= 1'b1;
        o_write_enable_n <= 1'b1;
    end
    else if (i_ce)
    begin
        in_s1_q <= i_mem_data;
        in_s2_q <= in_s1_q;
        o_rd_valid <= 1'b0;
        o_wr_ack <= 1'b0;
        o_timeout <= 1'b0;
        case (st_q)
            S_PWR:
            begin
                cnt_q <= cnt_q + 24'd1;
                if (cnt_q >= PWR_CYC[23:0])
                begin
                    st_q <= S_IDLE;
                    o_busy <= 1'b0;
                    cnt_q <= 24'h000000;
                end
            end
            S_IDLE:
            begin
                cnt_q <= 24'h000000;
                if (i_wr_req)
                begin
                    pend_a_q <= i_wr_addr;
                    pend_d_q <= i_wr_data;
                    pend_last_q <= i_wr_last;
                    page_q <= i_wr_addr[16:`PPE_PAGE_LSB];
                    unl_q <= 2'd0;
                    unl_done_q <= 1'b0;
                    o_busy <= 1'b1;
                    o_mem_addr <= unl_first[24:8];
                    o_mem_data <= unl_first[7:0];
                    st_q <= S_WSTB;
                end
                else if (i_rd_req)
                begin
                    o_busy <= 1'b1;
                    o_mem_addr <= i_rd_addr;
                    st_q <= S_RSTB;
                end
            end
            S_WSTB:
            begin
                o_output_enable_n <= 1'b1;
                o_mem_data_oe <= 1'b1;
                o_chip_enable_n <= 1'b0;
                o_write_enable_n <= 1'b0;
                cnt_q <= cnt_q + 24'd1;
                if ({8'h00, cnt_q} >= `PPE_STROBE_CYC)
                begin
                    o_write_enable_n <= 1'b1;
                    o_chip_enable_n <= 1'b1;
                    cnt_q <= 24'h000000;
                    st_q <= S_WGAP;
                end
            end
            S_WGAP:
            begin
                cnt_q <= cnt_q + 24'd1;
                if ({8'h00, cnt_q} >= `PPE_GAP_CYC)
                begin
                    o_mem_data_oe <= 1'b0;
                    cnt_q <= 24'h000000;
                    if (!unl_done_q)
                    begin
                        if (unl_q == 2'd2)
                        begin
                            unl_done_q <= 1'b1;
                            o_mem_addr <= pend_a_q;
                            o_mem_data <= pend_d_q;
                        end
                        else
                        begin
                            unl_q <= unl_q + 2'd1;
                            o_mem_addr <= unl_next[24:8];
                            o_mem_data <= unl_next[7:0];
                        end
                        st_q <= S_WSTB;
                    end
                    else
                    begin
                        o_wr_ack <= 1'b1;
                        last_a_q <= pend_a_q;
                        last_d_q <= pend_d_q;
                        st_q <= pend_last_q ? S_POLL : S_LOAD;
                    end
                end
            end
            S_LOAD:
            begin
                cnt_q <= cnt_q + 24'd1;
                if (i_wr_req && i_wr_addr[16:`PPE_PAGE_LSB] == page_q
                    && cnt_q < BLC_CYC[23:0])
                begin
                    pend_a_q <= i_wr_addr;
                    pend_d_q <= i_wr_data;
                    pend_last_q <= i_wr_last;
                    o_mem_addr <= i_wr_addr;
                    o_mem_data <= i_wr_data;
                    cnt_q <= 24'h000000;
                    st_q <= S_WSTB;
                end
                else if (i_wr_req || cnt_q >= BLC_CYC[23:0])
                begin
                    cnt_q <= 24'h000000;
                    st_q <= S_POLL;
                end
            end
            S_RSTB:
            begin
                o_chip_enable_n <= 1'b0;
                o_output_enable_n <= 1'b0;
                cnt_q <= cnt_q + 24'd1;
                if ({8'h00, cnt_q} >= `PPE_RD_CYC + 2)
                begin
                    o_rd_data <= in_s2_q;
                    o_chip_enable_n <= 1'b1;
                    o_output_enable_n <= 1'b1;
                    cnt_q <= 24'h000000;
                    st_q <= S_RGAP;
                end
            end
            S_RGAP:
            begin
                cnt_q <= cnt_q + 24'd1;
                if ({8'h00, cnt_q} >= `PPE_GAP_CYC)
                begin
                    cnt_q <= 24'h000000;
                    if (poll_q)
                    begin
                        if (o_rd_data[7] == last_d_q[7])
                        begin
                            poll_q <= 1'b0;
                            o_busy <= 1'b0;
                            st_q <= S_IDLE;
                        end
                        else if (wc_q >= WC_CYC[23:0])
                        begin
                            poll_q <= 1'b0;
                            o_busy <= 1'b0;
                            o_timeout <= 1'b1;
                            st_q <= S_IDLE;
                        end
                        else
                            st_q <= S_RSTB;
                    end
                    else
                    begin
                        o_rd_valid <= 1'b1;
                        o_busy <= 1'b0;
                        st_q <= S_IDLE;
                    end
                end
            end
            S_POLL:
            begin
                poll_q <= 1'b1;
                wc_q <= 24'h000000;
                o_mem_addr <= last_a_q;
                st_q <= S_RSTB;
            end
            default:
                st_q <= S_IDLE;
        endcase
        if (poll_q && wc_q != 24'hffffff)
            wc_q <= wc_q + 24'd1;
    end
end
endmodule

// >>> tb/ppe_dev_model.sv
// Behavioural model of the paged memory device
`timescale 1ns/1ps
module ppe_dev_model #(
    parameter real BLC_NS = 4000.0,
    parameter real WC_NS = 20000.0,
    parameter real PWR_NS = 1000.0
) (
    input wire [16:0] i_addr,
    input wire [7:0] i_data,
    input wire i_ce_n,
    input wire i_oe_n,
    input wire i_we_n,
    output wire [7:0] o_data,
    output wire o_drive
);
    reg [7:0] mem [0:131071];
    reg [7:0] pg [0:127];
    reg [7:0] id_area [0:127];
    reg [127:0] ld = 0;
    reg [16:0] la, lw;
    reg [7:0] lastd = 0;
    reg [1:0] step = 0;
    reg load = 0, busy = 0, tog = 0;
    realtime t_fall = 0, t_ev = 0;
    integer i;
    wire wr = ~i_ce_n & ~i_we_n & i_oe_n;
    assign o_drive = ~i_ce_n & ~i_oe_n & i_we_n;
    assign o_data = busy ? {~lastd[7], tog, lastd[5:0]} : mem[i_addr];
    initial for (i = 0; i < 131072; i = i + 1) mem[i] = 8'hff;
    always @(posedge wr)
    begin
        la = i_addr;
        t_fall = $realtime;
    end
    always @(negedge o_drive) if (busy) tog = ~tog;
    always @(negedge wr)
        if ($realtime - t_fall >= 15.0 && $realtime >= PWR_NS && !busy)
        begin
            if (load)
            begin
                pg[la[6:0]] = i_data;
                ld[la[6:0]] = 1'b1;
                lw = la;
                lastd = i_data;
                t_ev = $realtime;
            end
            else if (step == 0 && la == 17'h05555 && i_data == 8'haa) step = 1;
            else if (step == 1 && la == 17'h02aaa && i_data == 8'h55) step = 2;
            else if (step == 2 && la == 17'h05555 && i_data == 8'ha0)
            begin
                step = 0;
                load = 1;
                ld = 0;
                t_ev = $realtime;
            end
            else
            begin
                step = 0;
                busy = 1;
                t_ev = $realtime;
            end
        end
    always #100
        if (load && $realtime - t_ev > BLC_NS)
        begin
            for (i = 0; i < 128; i = i + 1)
                if (ld[i]) mem[{lw[16:7], i[6:0]}] = pg[i];
            load = 0;
            busy = 1;
            t_ev = $realtime;
        end
        else if (busy && $realtime - t_ev > WC_NS) busy = 0;
endmodule

// >>> tb/ppe_host_sva.sv
// Checker watching the controller pins
`timescale 1ns/1ps
module ppe_host_sva (
    input wire i_clk,
    input wire i_reset,
    input wire i_ce,
    input wire i_wr_req,
    input wire o_busy,
    input wire o_wr_ack,
    input wire o_rd_valid,
    input wire [16:0] o_mem_addr,
    input wire [7:0] o_mem_data,
    input wire o_mem_data_oe,
    input wire o_chip_enable_n,
    input wire o_output_enable_n,
    input wire o_write_enable_n
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    a_reset_safe: assert property (disable iff (1'b0) i_reset |=> o_write_enable_n
        && o_chip_enable_n && !o_mem_data_oe && o_busy && !o_wr_ack)
        else $error("pins not safe in reset");
    a_pwr_busy: assert property ($fell(i_reset) |-> o_busy [*8])
        else $error("busy low too early");
    a_unlock_first: assert property ((i_wr_req && i_ce && !o_busy) |-> ##[1:4]
        (!o_write_enable_n && o_mem_addr == 17'h05555 && o_mem_data == 8'haa))
        else $error("write not opened by unlock");
    a_strobe_len: assert property ($fell(o_write_enable_n) |-> !o_write_enable_n [*5])
        else $error("write strobe too short");
    a_addr_hold: assert property ((!o_write_enable_n && !$fell(o_write_enable_n))
        |-> $stable(o_mem_addr)) else $error("address moved in strobe");
    a_data_latch: assert property ($rose(o_write_enable_n)
        |-> $stable(o_mem_data) && o_mem_data_oe) else $error("data not held at rise");
    a_write_pins: assert property (!o_write_enable_n
        |-> !o_chip_enable_n && o_output_enable_n && o_mem_data_oe)
        else $error("bad write pins");
    a_read_pins: assert property (!o_output_enable_n
        |-> !o_mem_data_oe && o_write_enable_n) else $error("bus contention");
    a_ack_pulse: assert property (o_wr_ack |-> o_busy ##1 !o_wr_ack)
        else $error("bad write ack");
    a_rd_pulse: assert property (o_rd_valid |=> !o_rd_valid)
        else $error("bad read valid");
endmodule
bind ppe_host ppe_host_sva chk (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
    .i_wr_req(i_wr_req), .o_busy(o_busy), .o_wr_ack(o_wr_ack), .o_rd_valid(o_rd_valid),
    .o_mem_addr(o_mem_addr), .o_mem_data(o_mem_data), .o_mem_data_oe(o_mem_data_oe),
    .o_chip_enable_n(o_chip_enable_n), .o_output_enable_n(o_output_enable_n),
    .o_write_enable_n(o_write_enable_n));

// >>> tb/testbench.sv
// Self-checking bench for the paged memory host controller
`timescale 1ns/1ps
module testbench;
    reg i_clk = 0, i_reset = 1, i_ce = 1, i_rd_req = 0, i_wr_req = 0, i_wr_last = 0;
    reg [16:0] i_rd_addr = 0, i_wr_addr = 0;
    reg [7:0] i_wr_data = 0;
    wire [7:0] rd_data, mem_out, dev_data, bus;
    wire [16:0] mem_addr;
    wire rd_valid, wr_ack, busy, data_oe, ce_n, oe_n, we_n, drive, timeout;
    integer err_count = 0, checks_done = 0, n, to_count = 0;
    always @(negedge i_clk)
        if (!i_reset && timeout !== 1'b0) to_count = to_count + 1;
    assign bus = data_oe ? mem_out : (drive ? dev_data : ~dev_data);
    always #25 i_clk = ~i_clk;
    ppe_host #(.BLC_CYC(68), .WC_CYC(2000), .PWR_CYC(50)) dut (.i_clk(i_clk),
        .i_reset(i_reset), .i_ce(i_ce), .i_rd_req(i_rd_req), .i_rd_addr(i_rd_addr),
        .i_wr_req(i_wr_req), .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data),
        .i_wr_last(i_wr_last), .i_mem_data(bus), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
        .o_wr_ack(wr_ack), .o_busy(busy), .o_timeout(timeout), .o_mem_addr(mem_addr),
        .o_mem_data(mem_out), .o_mem_data_oe(data_oe), .o_chip_enable_n(ce_n),
        .o_output_enable_n(oe_n), .o_write_enable_n(we_n));
    ppe_dev_model dev (.i_addr(mem_addr), .i_data(bus), .i_ce_n(ce_n), .i_oe_n(oe_n),
        .i_we_n(we_n), .o_data(dev_data), .o_drive(drive));
    task give_verdict;
    begin
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    end
    endtask
    task hang(input string what);
    begin
        $display("BAD %s expected done seen hang", what);
        err_count = err_count + 1;
        give_verdict;
    end
    endtask
    task chk_byte(input string what, input [7:0] exp, input [7:0] got);
    begin
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            err_count = err_count + 1;
        end
    end
    endtask
    task wait_idle;
    begin
        n = 0;
        while (busy !== 1'b0 && n < 3000)
        begin
            @(posedge i_clk);
            #1 n = n + 1;
        end
        if (n == 3000) hang("idle");
    end
    endtask
    task do_wr(input [16:0] a, input [7:0] d, input l);
    begin
        @(negedge i_clk);
        {i_wr_req, i_wr_addr, i_wr_data, i_wr_last} = {1'b1, a, d, l};
        n = 0;
        while (wr_ack !== 1'b1 && n < 500)
        begin
            @(posedge i_clk);
            #1 n = n + 1;
        end
        if (n == 500) hang("wr_ack");
        @(negedge i_clk);
        i_wr_req = 0;
    end
    endtask
    task do_rd(input [16:0] a, input [7:0] exp);
    begin
        wait_idle;
        @(negedge i_clk);
        {i_rd_req, i_rd_addr} = {1'b1, a};
        n = 0;
        while (rd_valid !== 1'b1 && n < 500)
        begin
            @(posedge i_clk);
            #1 n = n + 1;
        end
        if (n == 500) hang("rd_valid");
        chk_byte("rd_data", exp, rd_data);
        @(negedge i_clk);
        i_rd_req = 0;
    end
    endtask
    task freeze_read(input [16:0] a, input [7:0] exp);
    begin
        wait_idle;
        @(negedge i_clk);
        {i_rd_req, i_rd_addr} = {1'b1, a};
        repeat (3) @(negedge i_clk);
        i_ce = 0;
        repeat (20) @(negedge i_clk);
        chk_byte("oe_n_frozen", 8'h00, {7'h00, oe_n});
        i_ce = 1;
        n = 0;
        while (rd_valid !== 1'b1 && n < 500)
        begin
            @(posedge i_clk);
            #1 n = n + 1;
        end
        if (n == 500) hang("rd_valid");
        chk_byte("rd_data", exp, rd_data);
        @(negedge i_clk);
        i_rd_req = 0;
    end
    endtask
    task page_load;
    begin
        wait_idle;
        do_wr({10'h0aa, 7'd5}, 8'h3c, 1'b0);
        do_wr({10'h0aa, 7'd2}, 8'h11, 1'b0);
        do_wr({10'h0aa, 7'd5}, 8'h42, 1'b1);
        do_rd({10'h0aa, 7'd5}, 8'h42);
        do_rd({10'h0aa, 7'd2}, 8'h11);
        do_rd({10'h0aa, 7'd3}, 8'hff);
        do_rd(17'h05555, 8'hff);
    end
    endtask
    task window_expiry;
    begin
        do_wr({10'h1f3, 7'd127}, 8'h07, 1'b0);
        do_rd({10'h1f3, 7'd127}, 8'h07);
    end
    endtask
    initial
    begin
        repeat (8) @(posedge i_clk);
        @(negedge i_clk);
        i_reset = 0;
        @(posedge i_clk);
        #1 chk_byte("busy", 8'h01, {7'h00, busy});
        page_load;
        window_expiry;
        freeze_read({10'h0aa, 7'd2}, 8'h11);
        chk_byte("timeout", 8'h00, to_count[7:0]);
        give_verdict;
    end
endmodule
